// >>> verilog/dcs_sequencer.sv
`timescale 1ns/100ps
`include "dcs_defines.svh"
// Behaviour
// [RULE1] Control word: select 00, address 1100
// [RULE2] Bit 11: power-down output, 1 high-Z
// [RULE3] Bit 10: internal reference 2.5 or 1.25
// [RULE4] Bit 9: amplifier boost, default off
// [RULE5] Bit 8: internal reference enable, default off
// [RULE6] Bit 7: channel monitor enable, default off
// [RULE7] Bit 6: thermal shutdown, soft power-up re-enables
// [RULE8] Bits 1/0: toggle groups high/low
// [RULE9] Reset falling edge restores all registers
// [RULE10] Reset: gain full, offset zero, DAC zero
// [RULE11] Busy low during reset, 270 us
// [RULE12] During reset reject traffic and strobes
// [RULE13] After reset ignore pin until next edge
// [RULE14] Clear edge loads clear code, busy low
// [RULE15] Clear takes 20 us with busy low
// [RULE16] Busy low during calc and power-on
// [RULE17] Strobe during busy stored, applied at end
// [RULE18] Strobe updates only freshly written channels; channels in an enabled toggle group here switch A/B on every strobe
// [RULE19] Power-on: defaults, outputs high-Z, busy low
// [RULE20] Global power-down keeps all registers
// [RULE21] Pins synchronised, falling edges detected
module dcs_sequencer #(
	parameter int CH_NUM = 16,
	parameter int DW = 12,
	parameter int RESET_CYC = `DCS_RESET_CYC,
	parameter logic REF_2V5_DEFAULT = 1'b1
) (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic LINK_CLK_I,
	input wire logic LINK_WR_I,
	input wire dcs_pkg::dcs_word_s LINK_WORD_I,
	output logic LINK_RDY_O,
	input wire logic RESET_N_I,
	input wire logic CLR_N_I,
	input wire logic LOAD_DAC_STROBE_N_I,
	input wire logic TEMP_OVER_I,
	output logic BUSY_N_O,
	output logic PD_HIZ_O,
	output logic REF_2V5_O,
	output logic BOOST_O,
	output logic REF_INT_O,
	output logic MON_EN_O,
	output logic AMP_EN_O,
	output logic OUT_HIZ_O,
	output logic [CH_NUM*DW-1:0] DAC_CODE_O
);

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: word holding register and request toggle
	logic lrst_s1_q, lrst_s2_q; // Core reset brought into link domain
	logic lack_s1_q, lack_s2_q; // Acknowledge toggle synchroniser
	logic lreq_q; // Request toggle
	dcs_pkg::dcs_word_s lword_q; // Word held stable until acknowledged
	logic ack_q; // Core acknowledge toggle

	logic [3:0] lrst_cnt_q; // Core cycles left of the stretched reset
	logic lrst_hold_q; // Reset as offered to the link domain

	// A short power-on reset can fall between two link edges, so stretch it here;
	// link clocks slower than about 3 MHz would need a longer stretch
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			lrst_cnt_q <= 4'hF;
			lrst_hold_q <= 1'b1;
		end else begin
			lrst_cnt_q <= lrst_cnt_q - 4'(lrst_cnt_q != 4'h0);
			lrst_hold_q <= (lrst_cnt_q != 4'h0);
		end
	end

	// Synchronisers into the link domain
	always_ff @(posedge LINK_CLK_I) begin
		lrst_s1_q <= lrst_hold_q;
		lrst_s2_q <= lrst_s1_q;
		lack_s1_q <= ack_q;
		lack_s2_q <= lack_s1_q;
	end

	// Ready once the previous word was consumed by the core
	assign LINK_RDY_O = (lreq_q == lack_s2_q);

	// Capture a word; the holding register must not move until acked
	always_ff @(posedge LINK_CLK_I) begin
		if (lrst_s2_q) begin
			lreq_q <= 1'b0;
			lword_q <= '0;
		end else if (LINK_WR_I && LINK_RDY_O) begin
			lword_q <= LINK_WORD_I;
			lreq_q <= ~lreq_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Core domain synchronisers
	logic req_s1_q, req_s2_q; // Request toggle into core
	logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q; // {temp, strobe, clear, reset}
	logic rst_fall, clr_fall, load_dac_strobe_fall, load_dac_strobe_low, over_temp;

	// Two flops before use; third stage only for edge detection
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			pin_s1_q <= `DCS_PIN_IDLE;
			pin_s2_q <= `DCS_PIN_IDLE;
			pin_s3_q <= `DCS_PIN_IDLE;
		end else begin
			req_s1_q <= lreq_q;
			req_s2_q <= req_s1_q;
			pin_s1_q <= {TEMP_OVER_I, LOAD_DAC_STROBE_N_I, CLR_N_I, RESET_N_I}; // RULE21
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Falling edges plus strobe and temperature levels; the reset level itself is never looked at
	assign rst_fall = pin_s3_q[0] & ~pin_s2_q[0]; // RULE13
	assign clr_fall = pin_s3_q[1] & ~pin_s2_q[1]; // RULE21
	assign load_dac_strobe_fall = pin_s3_q[2] & ~pin_s2_q[2];
	assign load_dac_strobe_low = ~pin_s2_q[2];
	assign over_temp = pin_s2_q[3];

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	dcs_pkg::dcs_state_e st_q; // Current state
	logic [13:0] cnt_q; // Cycles spent in state
	logic [13:0] cnt_lim; // Last count of the current state
	logic cnt_last, busy_end, word_vld, take, wr_en, calc_start;
	logic por_done_q; // First reset sequence finished
	dcs_pkg::dcs_word_s cw_q; // Word under calibration

	assign word_vld = (req_s2_q != ack_q);
	// Traffic arriving during reset is taken and dropped
	assign take = word_vld && ((st_q == dcs_pkg::ST_IDLE && !rst_fall && !clr_fall) ||
		st_q == dcs_pkg::ST_RESET); // RULE12
	assign wr_en = take && (st_q == dcs_pkg::ST_IDLE);
	assign calc_start = wr_en && (lword_q.reg_sel == `DCS_SEL_DATA);

	// Length of each busy phase
	always_comb begin
		case (st_q)
			dcs_pkg::ST_RESET: cnt_lim = 14'(RESET_CYC - 1); // RULE11
			dcs_pkg::ST_CLEAR: cnt_lim = 14'(`DCS_CLEAR_CYC - 1); // RULE15
			default: cnt_lim = 14'(`DCS_CALC_CYC - 1);
		endcase
	end
	assign cnt_last = (cnt_q == cnt_lim);
	assign busy_end = (st_q == dcs_pkg::ST_CLEAR || st_q == dcs_pkg::ST_CALC) &&
		cnt_last && !rst_fall;

	// Busy is the idle bit of the one-hot state
	assign BUSY_N_O = (st_q == dcs_pkg::ST_IDLE); // RULE16

	// Acknowledge every word taken
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			ack_q <= 1'b0;
		end else if (take) begin
			ack_q <= req_s2_q;
		end
	end

	// State and phase counter; a reset edge pre-empts any phase
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			st_q <= dcs_pkg::ST_RESET; // RULE19
			cnt_q <= '0;
			por_done_q <= 1'b0;
		end else begin
			case (st_q)
				dcs_pkg::ST_IDLE: begin
					cnt_q <= '0;
					if (rst_fall) begin
						st_q <= dcs_pkg::ST_RESET; // RULE9
					end else if (clr_fall) begin
						st_q <= dcs_pkg::ST_CLEAR; // RULE14
					end else if (calc_start) begin
						st_q <= dcs_pkg::ST_CALC; // RULE16
					end
				end
				dcs_pkg::ST_RESET: begin
					if (rst_fall) begin
						cnt_q <= '0; // A fresh edge restarts the sequence
					end else if (cnt_last) begin
						st_q <= dcs_pkg::ST_IDLE; // RULE13
						cnt_q <= '0;
						por_done_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 14'h1;
					end
				end
				dcs_pkg::ST_CLEAR, dcs_pkg::ST_CALC: begin
					if (rst_fall) begin
						st_q <= dcs_pkg::ST_RESET;
						cnt_q <= '0;
					end else if (cnt_last) begin
						st_q <= dcs_pkg::ST_IDLE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 14'h1;
					end
				end
				default: begin
					st_q <= dcs_pkg::ST_RESET;
					cnt_q <= '0;
				end
			endcase
		end
	end

	// Hold the word being calibrated
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			cw_q <= '0;
		end else if (calc_start) begin
			cw_q <= lword_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strobe memory
	logic pend_q; // Strobe seen while busy
	logic post_q; // Apply in the cycle after busy rises
	logic apply; // Load DAC registers now

	// Strobes in reset are dropped; in calc or clear they are stored
	always_ff @(posedge MCLK_I) begin
		if (RST_I || rst_fall || st_q == dcs_pkg::ST_RESET) begin
			pend_q <= 1'b0; // RULE12
			post_q <= 1'b0;
		end else begin
			post_q <= busy_end && (pend_q || load_dac_strobe_low); // RULE17
			if (load_dac_strobe_fall && (st_q == dcs_pkg::ST_CLEAR || st_q == dcs_pkg::ST_CALC) &&
				!busy_end) begin
				pend_q <= 1'b1; // RULE17
			end else if (busy_end) begin
				pend_q <= 1'b0;
			end
		end
	end
	assign apply = (st_q == dcs_pkg::ST_IDLE) && !rst_fall && !clr_fall &&
		(load_dac_strobe_fall || post_q);

	////////////////////////////////////////////////////////////////////////////////
	// Control, clear code and power state
	logic [DW-1:0] ctrl_q; // Control word
	logic [DW-1:0] clr_code_q; // Clear code
	logic soft_pd_q; // Global power-down
	logic therm_pd_q; // Thermal shutdown latched
	logic amp_en_q; // Amplifiers running

	// Restored by power-on and by each reset edge
	always_ff @(posedge MCLK_I) begin
		if (RST_I || rst_fall) begin
			ctrl_q <= `DCS_CTRL_RESET; // RULE2 RULE4 RULE5 RULE6 RULE7
			ctrl_q[`DCS_REF_SEL_BIT] <= REF_2V5_DEFAULT; // RULE3
			clr_code_q <= `DCS_CLRCODE_RESET;
			soft_pd_q <= 1'b0;
			therm_pd_q <= 1'b0;
		end else begin
			if (wr_en && lword_q.reg_sel == `DCS_SEL_SPECIAL) begin
				case (lword_q.addr)
					`DCS_ADDR_CTRL: ctrl_q <= lword_q.data; // RULE1
					`DCS_ADDR_CLRCODE: clr_code_q <= lword_q.data;
					`DCS_ADDR_PWR: begin
						soft_pd_q <= lword_q.data[0]; // RULE20
						if (!lword_q.data[0] && !over_temp) begin
							therm_pd_q <= 1'b0; // RULE7
						end
					end
					default: ;
				endcase
			end
			// Set beats a soft power-up in the same cycle
			if (ctrl_q[`DCS_THERM_BIT] && over_temp) begin
				therm_pd_q <= 1'b1; // RULE7
			end
		end
	end

	// Power-down gates the amplifiers only; no register is touched
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			amp_en_q <= 1'b0;
		end else begin
			amp_en_q <= por_done_q && !soft_pd_q && !therm_pd_q; // RULE20
		end
	end

	assign PD_HIZ_O = ctrl_q[`DCS_PD_STATE_BIT]; // RULE2
	assign REF_2V5_O = ctrl_q[`DCS_REF_SEL_BIT]; // RULE3
	assign BOOST_O = ctrl_q[`DCS_BOOST_BIT]; // RULE4
	assign REF_INT_O = ctrl_q[`DCS_REF_INT_BIT]; // RULE5
	assign MON_EN_O = ctrl_q[`DCS_MON_EN_BIT]; // RULE6
	assign AMP_EN_O = amp_en_q;
	assign OUT_HIZ_O = ~por_done_q; // RULE19

	////////////////////////////////////////////////////////////////////////////////
	// Channel registers and calibration
	logic [DW-1:0] gain_q [CH_NUM]; // Gain per channel
	logic [DW-1:0] offs_q [CH_NUM]; // Offset per channel
	logic [DW-1:0] x2a_q [CH_NUM]; // Calibrated A codes
	logic [DW-1:0] x2b_q [CH_NUM]; // Calibrated B codes
	logic [DW-1:0] dac_q [CH_NUM]; // DAC registers
	logic [CH_NUM-1:0] dirty_q; // A code written since last strobe
	logic [CH_NUM-1:0] absel_q; // Toggle phase, 1 shows B
	logic [2*DW:0] cal_prod; // Code times gain plus one
	logic [DW+1:0] cal_sum; // Scaled code plus offset
	logic [DW-1:0] cal_val; // Saturated result
	logic calc_wr; // Result written this cycle

	// Saturating y = x * (m + 1) / 4096 + c
	assign cal_prod = cw_q.data * {1'b0, gain_q[cw_q.addr]} +
		(2*DW+1)'(cw_q.data);
	assign cal_sum = {1'b0, cal_prod[2*DW:DW]} + {2'b00, offs_q[cw_q.addr]};
	assign cal_val = cal_sum[DW+1:DW] != 2'b00 ? {DW{1'b1}} : cal_sum[DW-1:0];
	assign calc_wr = (st_q == dcs_pkg::ST_CALC) && cnt_last && !rst_fall;

	// Channel storage: restore, writes, clear load and strobe updates
	always_ff @(posedge MCLK_I) begin
		if (RST_I || rst_fall) begin
			for (int i = 0; i < CH_NUM; i++) begin
				gain_q[i] <= `DCS_GAIN_RESET; // RULE10
				offs_q[i] <= `DCS_OFFSET_RESET; // RULE10
				x2a_q[i] <= `DCS_DAC_RESET;
				x2b_q[i] <= `DCS_DAC_RESET;
				dac_q[i] <= `DCS_DAC_RESET; // RULE10
			end
			dirty_q <= '0;
			absel_q <= '0;
		end else begin
			if (wr_en && lword_q.reg_sel == `DCS_SEL_GAIN) begin
				gain_q[lword_q.addr] <= lword_q.data;
			end
			if (wr_en && lword_q.reg_sel == `DCS_SEL_OFFSET) begin
				offs_q[lword_q.addr] <= lword_q.data;
			end
			if (calc_wr) begin
				if (cw_q.ab_sel) begin
					x2b_q[cw_q.addr] <= cal_val;
				end else begin
					x2a_q[cw_q.addr] <= cal_val;
					dirty_q[cw_q.addr] <= 1'b1; // RULE18
				end
			end
			if (st_q == dcs_pkg::ST_IDLE && clr_fall) begin
				for (int i = 0; i < CH_NUM; i++) begin
					dac_q[i] <= clr_code_q; // RULE14
				end
			end
			// Never coincides with a calc write: apply only in idle
			if (apply) begin
				for (int i = 0; i < CH_NUM; i++) begin
					if (ctrl_q[i < 8 ? `DCS_TOG_LO_BIT : `DCS_TOG_HI_BIT]) begin
						absel_q[i] <= ~absel_q[i]; // RULE8
						dac_q[i] <= absel_q[i] ? x2a_q[i] : x2b_q[i];
					end else if (dirty_q[i]) begin
						dac_q[i] <= x2a_q[i]; // RULE18
						dirty_q[i] <= 1'b0;
					end
				end
			end
		end
	end

	// Flatten DAC registers onto the output bus
	for (genvar g = 0; g < CH_NUM; g++) begin : g_out
		assign DAC_CODE_O[g*DW +: DW] = dac_q[g];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (RST_I);

	sequence seq_busy_hold;
		(!BUSY_N_O) [*8];
	endsequence

	reset_entry_a: assert property (rst_fall |=> st_q == dcs_pkg::ST_RESET && cnt_q == 14'h0) // RULE9
		else $error("reset edge did not restart the sequence");
	reset_busy_a: assert property (rst_fall |=> seq_busy_hold) // RULE11
		else $error("busy not held low after reset edge");
	reset_len_a: assert property (st_q == dcs_pkg::ST_RESET |-> cnt_q < 14'(RESET_CYC)) // RULE11
		else $error("reset sequence overran");
	reset_values_a: assert property (st_q == dcs_pkg::ST_RESET |-> // RULE10
		dac_q[0] == `DCS_DAC_RESET && gain_q[0] == `DCS_GAIN_RESET && offs_q[0] == 12'h0)
		else $error("registers not at reset values");
	reset_reject_a: assert property (st_q == dcs_pkg::ST_RESET && word_vld |=> $stable(ctrl_q)) // RULE12
		else $error("write accepted during reset");
	clear_load_a: assert property (st_q == dcs_pkg::ST_IDLE && clr_fall && !rst_fall |=> // RULE14
		!BUSY_N_O && dac_q[CH_NUM-1] == $past(clr_code_q))
		else $error("clear code not loaded");
	clear_len_a: assert property (st_q == dcs_pkg::ST_CLEAR |-> cnt_q < 14'(`DCS_CLEAR_CYC)) // RULE15
		else $error("clear overran");
	calc_busy_a: assert property (calc_start |=> !BUSY_N_O) // RULE16
		else $error("busy not low during calculation");
	load_dac_strobe_store_a: assert property (load_dac_strobe_fall && !rst_fall && !busy_end && // RULE17
		(st_q == dcs_pkg::ST_CLEAR || st_q == dcs_pkg::ST_CALC) |=> pend_q)
		else $error("strobe during busy not stored");
	dirty_only_a: assert property (apply && !dirty_q[0] && !ctrl_q[`DCS_TOG_LO_BIT] |=> // RULE18
		$stable(dac_q[0]))
		else $error("unchanged channel was updated");
	thermal_off_a: assert property (ctrl_q[`DCS_THERM_BIT] && over_temp && !rst_fall |=> // RULE7
		##1 !AMP_EN_O)
		else $error("amplifiers left on when hot");

endmodule // dcs_sequencer

// >>> verilog/dcs_defines.svh
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
// Core clock rate and sequence times
`define DCS_CLK_MHZ 50
`define DCS_RESET_US 270
`define DCS_RESET_CYC (`DCS_RESET_US * `DCS_CLK_MHZ)
`define DCS_CLEAR_US 20
`define DCS_CLEAR_CYC (`DCS_CLEAR_US * `DCS_CLK_MHZ)
`define DCS_CALC_NS 100
`define DCS_CALC_CYC ((`DCS_CALC_NS * `DCS_CLK_MHZ) / 1000)
// Register select codes
`define DCS_SEL_SPECIAL 2'h0
`define DCS_SEL_GAIN 2'h1
`define DCS_SEL_OFFSET 2'h2
`define DCS_SEL_DATA 2'h3
// Special addresses
`define DCS_ADDR_CTRL 4'hC
`define DCS_ADDR_CLRCODE 4'hD
`define DCS_ADDR_PWR 4'h8
// Control word bit positions
`define DCS_PD_STATE_BIT 11
`define DCS_REF_SEL_BIT 10
`define DCS_BOOST_BIT 9
`define DCS_REF_INT_BIT 8
`define DCS_MON_EN_BIT 7
`define DCS_THERM_BIT 6
`define DCS_TOG_HI_BIT 1
`define DCS_TOG_LO_BIT 0
// Reset values
`define DCS_CTRL_RESET 12'h800
`define DCS_GAIN_RESET 12'hFFF
`define DCS_OFFSET_RESET 12'h000
`define DCS_DAC_RESET 12'h000
`define DCS_CLRCODE_RESET 12'h000
`define DCS_PIN_IDLE 4'h7
`endif

// >>> verilog/dcs_pkg.sv
package dcs_pkg;
	// One host word as delivered by the deframed link
	typedef struct packed {
		logic [1:0] reg_sel;
		logic ab_sel;
		logic [3:0] addr;
		logic [11:0] data;
	} dcs_word_s;
	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RESET = 4'h2,
		ST_CLEAR = 4'h4,
		ST_CALC = 4'h8
	} dcs_state_e;
endpackage

// >>> test/dcs_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Host side of the word link: one word outstanding at a time
module dcs_host_model (
	input wire logic link_clk_i,
	input wire logic link_rdy_i,
	output logic link_wr_o,
	output dcs_pkg::dcs_word_s link_word_o
);
	// Idle link at time zero
	initial begin
		link_wr_o = 1'b0;
		link_word_o = '0;
	end

	// Offer one word, hold it until taken, then wait for the ack to return
	task automatic send(input logic [1:0] sel, input logic ab, input logic [3:0] addr,
		input logic [11:0] data);
		@(posedge link_clk_i iff link_rdy_i);
		link_wr_o <= 1'b1;
		link_word_o <= '{reg_sel: sel, ab_sel: ab, addr: addr, data: data};
		@(posedge link_clk_i iff link_rdy_i);
		link_wr_o <= 1'b0;
		// Released fields show the inverse so stale data never passes for valid
		link_word_o <= ~link_word_o;
		// Ready may lag the take by an edge, so skip past it before waiting
		repeat (2) @(posedge link_clk_i);
		@(posedge link_clk_i iff link_rdy_i);
	endtask
endmodule // dcs_host_model

// >>> test/dac_control_sequencer_tb.sv
`timescale 1ns/100ps
`include "dcs_defines.svh"
module dac_control_sequencer_tb;
	localparam int RC = 20; // Shortened reset sequence keeps the run short
	logic mclk = 1'b0;
	logic lclk = 1'b0;
	logic rst = 1'b1;
	logic reset_n = 1'b1;
	logic clr_n = 1'b1;
	logic load_dac_strobe_n = 1'b1;
	logic temp_over = 1'b0;
	logic link_wr, link_rdy, busy_n, pd_hiz, ref_2v5, boost, ref_int, mon_en, amp_en, out_hiz;
	dcs_pkg::dcs_word_s link_word;
	logic [191:0] dac;
	int miscompares = 0;
	int checks = 0;

	// Core clock 50 MHz, link clock 8 MHz with unrelated phase
	always #10 mclk = ~mclk;
	always #62.5 lclk = ~lclk;

	dcs_sequencer #(.RESET_CYC(RC)) uut (.MCLK_I(mclk), .RST_I(rst), .LINK_CLK_I(lclk),
		.LINK_WR_I(link_wr), .LINK_WORD_I(link_word), .LINK_RDY_O(link_rdy),
		.RESET_N_I(reset_n), .CLR_N_I(clr_n), .LOAD_DAC_STROBE_N_I(load_dac_strobe_n), .TEMP_OVER_I(temp_over),
		.BUSY_N_O(busy_n), .PD_HIZ_O(pd_hiz), .REF_2V5_O(ref_2v5), .BOOST_O(boost),
		.REF_INT_O(ref_int), .MON_EN_O(mon_en), .AMP_EN_O(amp_en), .OUT_HIZ_O(out_hiz),
		.DAC_CODE_O(dac));
	dcs_host_model host (.link_clk_i(lclk), .link_rdy_i(link_rdy), .link_wr_o(link_wr),
		.link_word_o(link_word));

	////////////////////////////////////////
	// Compare and count
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic close_out;
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	function automatic logic [11:0] ctrl5();
		return {7'h00, pd_hiz, ref_2v5, boost, ref_int, mon_en};
	endfunction

	function automatic logic [11:0] ch(input int g);
		return dac[g*12+:12];
	endfunction

	// Wait for busy to reach a level, bounded
	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (busy_n !== lvl && n < lim) begin
			@(negedge mclk);
			n++;
		end
	endtask

	// Count the falling core edges at which busy is seen low, from the first one on
	task automatic busy_span(output int n);
		int k;
		n = 0;
		k = 0;
		while ((n == 0 || busy_n === 1'b0) && k < 5000) begin
			@(negedge mclk);
			k++;
			if (busy_n === 1'b0) begin
				n++;
			end
		end
	endtask

	// Strobe low long enough to clear the pin synchronisers
	task automatic load_dac_strobe_pulse;
		@(posedge mclk) load_dac_strobe_n <= 1'b0;
		repeat (3) @(posedge mclk);
		load_dac_strobe_n <= 1'b1;
		repeat (4) @(negedge mclk);
	endtask

	////////////////////////////////////////
	task automatic t_por;
		int n;
		@(negedge mclk);
		chk("por busy", {11'h000, busy_n}, 12'h000);
		chk("por ctrl", ctrl5(), 12'h018);
		chk("por out", {10'h000, out_hiz, amp_en}, 12'h002);
		chk("por dac", {11'h000, |dac}, 12'h000);
		@(posedge mclk) rst <= 1'b0;
		busy_span(n);
		chk("por span", 12'(n), 12'(RC));
		repeat (2) @(negedge mclk);
		chk("por end", {10'h000, out_hiz, amp_en}, 12'h001);
	endtask

	task automatic t_ctrl;
		logic [11:0] w [2] = '{12'hC00, 12'h3C3};
		logic [11:0] e [2] = '{12'h018, 12'h007};
		for (int i = 0; i < 2; i++) begin
			host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_CTRL, w[i]);
			repeat (4) @(negedge mclk);
			chk("ctrl bits", ctrl5(), e[i]);
		end
	endtask

	// Over-temperature latch, soft power-up and global power-down
	task automatic t_therm;
		@(posedge mclk) temp_over <= 1'b1;
		repeat (6) @(negedge mclk);
		chk("therm off", {11'h000, amp_en}, 12'h000);
		host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_PWR, 12'h000);
		repeat (4) @(negedge mclk);
		chk("power-up hot", {11'h000, amp_en}, 12'h000);
		@(posedge mclk) temp_over <= 1'b0;
		repeat (6) @(negedge mclk);
		chk("therm latched", {11'h000, amp_en}, 12'h000);
		host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_PWR, 12'h000);
		repeat (4) @(negedge mclk);
		chk("power-up cool", {11'h000, amp_en}, 12'h001);
		host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_PWR, 12'h001);
		repeat (4) @(negedge mclk);
		chk("pd amp", {11'h000, amp_en}, 12'h000);
		chk("pd ctrl kept", ctrl5(), 12'h007);
		host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_PWR, 12'h000);
		repeat (4) @(negedge mclk);
		chk("pd exit", {11'h000, amp_en}, 12'h001);
	endtask

	// Toggle group high, strobe edge and strobe held low
	task automatic t_load;
		host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_CTRL, 12'h002);
		host.send(`DCS_SEL_DATA, 1'b1, 4'h9, 12'h123);
		host.send(`DCS_SEL_DATA, 1'b0, 4'h9, 12'h456);
		wait_busy(1'b1, 50);
		@(posedge mclk) load_dac_strobe_n <= 1'b0;
		repeat (6) @(negedge mclk);
		chk("ch9 first", ch(9), 12'h123);
		chk("ch3 unwritten", ch(3), 12'h000);
		host.send(`DCS_SEL_DATA, 1'b0, 4'h3, 12'h5A5);
		repeat (10) @(negedge mclk);
		chk("ch3 held", ch(3), 12'h5A5);
		chk("ch9 second", ch(9), 12'h456);
		@(posedge mclk) load_dac_strobe_n <= 1'b1;
		load_dac_strobe_pulse();
		chk("ch9 third", ch(9), 12'h123);
	endtask

	// Clear with a strobe stored while busy
	task automatic t_clear;
		int n;
		host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_CLRCODE, 12'hABC);
		host.send(`DCS_SEL_DATA, 1'b0, 4'h3, 12'h0F0);
		wait_busy(1'b1, 50);
		@(posedge mclk) clr_n <= 1'b0;
		fork
			busy_span(n);
			begin
				repeat (20) @(posedge mclk);
				chk("clr ch3", ch(3), 12'hABC);
				load_dac_strobe_n <= 1'b0;
				repeat (3) @(posedge mclk);
				load_dac_strobe_n <= 1'b1;
				clr_n <= 1'b1;
			end
		join
		chk("clr span", 12'(n), 12'(`DCS_CLEAR_CYC));
		repeat (3) @(negedge mclk);
		chk("stored ch3", ch(3), 12'h0F0);
		chk("kept ch0", ch(0), 12'hABC);
	endtask

	// Pin reset restores gain, control and outputs
	task automatic t_reset;
		int n;
		host.send(`DCS_SEL_GAIN, 1'b0, 4'h0, 12'h7FF);
		host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_CTRL, 12'h3C3);
		wait_busy(1'b1, 50);
		@(posedge mclk) reset_n <= 1'b0;
		// A control write offered inside the reset sequence must be dropped
		fork
			busy_span(n);
			host.send(`DCS_SEL_SPECIAL, 1'b0, `DCS_ADDR_CTRL, 12'h3C3);
		join
		chk("reset span", 12'(n), 12'(RC));
		chk("reset dac", {11'h000, |dac}, 12'h000);
		chk("reset ctrl", ctrl5(), 12'h018);
		repeat (30) @(negedge mclk);
		chk("pin low ignored", {11'h000, busy_n}, 12'h001);
		@(posedge mclk) reset_n <= 1'b1;
		host.send(`DCS_SEL_DATA, 1'b0, 4'h0, 12'h800);
		wait_busy(1'b1, 50);
		load_dac_strobe_pulse();
		chk("full gain", ch(0), 12'h800);
	endtask

	////////////////////////////////////////
	initial begin
		t_por();
		t_ctrl();
		t_therm();
		t_load();
		t_clear();
		t_reset();
		close_out();
	end

	// Watchdog well beyond the expected run
	initial begin
		#400000;
		miscompares++;
		close_out();
	end
endmodule // dac_control_sequencer_tb
